// *** logic/fmc_pkg.sv ***
package fmc_pkg;
  // geometry
  localparam int unsigned PAGE_BYTES      = 512;
  localparam int unsigned ROW_BYTES       = 64;
  localparam int unsigned ROWS_PER_PAGE   = 8;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned PAGE_W          = 5;
  localparam int unsigned OFS_W           = 9;
  localparam int unsigned ROW_W           = 3;
  localparam int unsigned COL_W           = 6;
  localparam int unsigned OPT_BYTES       = 2;
  // variant sizes in bytes
  localparam logic [15:0] SIZE_1K         = 16'h0400;
  localparam logic [15:0] SIZE_2K         = 16'h0800;
  localparam logic [15:0] SIZE_4K         = 16'h1000;
  localparam logic [15:0] SIZE_8K         = 16'h2000;
  localparam logic [15:0] SIZE_12K        = 16'h3000;
  localparam logic [2:0]  VAR_1K          = 3'h0;
  localparam logic [2:0]  VAR_2K          = 3'h1;
  localparam logic [2:0]  VAR_4K          = 3'h2;
  localparam logic [2:0]  VAR_8K          = 3'h3;
  localparam logic [2:0]  VAR_12K         = 3'h4;
  localparam logic [1:0]  PPS_ONE         = 2'h1;
  localparam logic [1:0]  PPS_TWO         = 2'h2;
  localparam logic [1:0]  PPS_THREE       = 2'h3;
  // information area
  localparam logic [15:0] INFO_BASE       = 16'hFE00;
  localparam logic [15:0] INFO_LAST       = 16'hFE7F;
  localparam logic [15:0] PARTNO_FIRST    = 16'hFE40;
  localparam logic [15:0] PARTNO_LAST     = 16'hFE53;
  localparam int unsigned INFO_BYTES      = 128;
  localparam int unsigned INFO_W          = 7;
  localparam int unsigned INFO_EN_BIT     = 7;
  localparam logic [7:0]  PAD_BYTE        = 8'hFF;
  localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
  // trim indices inside information area
  localparam logic [6:0]  TRIM_BOD_IDX    = 7'h00;
  localparam logic [6:0]  TRIM_OSC_IDX    = 7'h01;
  localparam logic [6:0]  TRIM_ADC_IDX    = 7'h02;
  // AXI register map (byte addresses)
  localparam logic [7:0]  A_PAGE_SEL      = 8'h00;
  localparam logic [7:0]  A_CTRL          = 8'h04;
  localparam logic [7:0]  A_FREQ_HI       = 8'h08;
  localparam logic [7:0]  A_FREQ_LO       = 8'h0C;
  localparam logic [7:0]  A_STATUS        = 8'h10;
  localparam logic [7:0]  A_SECT_PROT     = 8'h14;
  localparam logic [7:0]  A_OPTIONS       = 8'h18;
  localparam logic [7:0]  A_TRIM_BOD      = 8'h1C;
  localparam logic [7:0]  A_TRIM_OSC      = 8'h20;
  localparam logic [7:0]  A_TRIM_ADC      = 8'h24;
  localparam logic [7:0]  A_MEM_ADDR      = 8'h28;
  localparam logic [7:0]  A_MEM_DATA      = 8'h2C;
  // control commands
  localparam logic [7:0]  CMD_PROG        = 8'h01;
  localparam logic [7:0]  CMD_PAGE_ERASE  = 8'h95;
  localparam logic [7:0]  CMD_MASS_ERASE  = 8'h63;
  // option bit positions
  localparam int unsigned OPT_RDPROT_BIT  = 0;
  localparam int unsigned OPT_WPROT_BIT   = 1;
  localparam int unsigned OPT_DMWBLK_BIT  = 2;
  localparam logic [7:0]  OPT_RESET       = 8'hFF;
  // timing in microseconds, per kHz of clock
  localparam logic [15:0] T_PROG_US       = 16'h0028;
  localparam logic [15:0] T_PAGE_US       = 16'h2710;
  localparam logic [15:0] T_MASS_US       = 16'h4E20;
  localparam logic [15:0] KHZ_PER_MS      = 16'h03E8;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  typedef enum logic [1:0] {
    FMC_IDLE  = 2'b00,
    FMC_PROG  = 2'b01,
    FMC_PAGE  = 2'b10,
    FMC_MASS  = 2'b11
  } fmc_state_e;
endpackage

// *** logic/fmc_ctrl.sv ***
`timescale 1ns/1ps
module fmc_ctrl
  import fmc_pkg::*;
#(
  parameter logic [2:0] VARIANT = VAR_4K
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  // AXI4-Lite slave
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // read port from CPU / debugger
  input  wire logic [15:0] i_rd_addr,
  input  wire logic        i_rd_en,
  input  wire logic        i_rd_dbg,
  output logic [7:0]       o_rd_data,
  output logic             o_rd_refused,
  input  wire logic        i_dm_wr,
  output logic             o_dm_wr_block,
  // flash array
  output logic [PAGE_W-1:0] o_fa_page,
  output logic [ROW_W-1:0]  o_fa_row,
  output logic [COL_W-1:0]  o_fa_col,
  output logic [7:0]        o_fa_wdata,
  output logic              o_fa_prog,
  output logic              o_fa_erase_page,
  output logic              o_fa_erase_mass,
  output logic              o_fa_info_sel,
  input  wire logic [7:0]   i_fa_rdata,
  input  wire logic [7:0]   i_info_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // variant geometry
  logic [15:0] flash_size;
  logic [1:0]  pages_per_sect;
  always_comb begin
    case (VARIANT)
      VAR_1K:  begin flash_size = SIZE_1K;  pages_per_sect = PPS_ONE;   end
      VAR_2K:  begin flash_size = SIZE_2K;  pages_per_sect = PPS_ONE;   end
      VAR_4K:  begin flash_size = SIZE_4K;  pages_per_sect = PPS_ONE;   end
      VAR_8K:  begin flash_size = SIZE_8K;  pages_per_sect = PPS_TWO;   end
      VAR_12K: begin flash_size = SIZE_12K; pages_per_sect = PPS_THREE; end
      default: begin flash_size = SIZE_4K;  pages_per_sect = PPS_ONE;   end
    endcase
  end

  function automatic logic [2:0] sect_of(input logic [PAGE_W-1:0] pg, input logic [1:0] pps);
    logic [2:0] s;
    s = 3'h0;
    case (pps)
      PPS_TWO:   s = pg[3:1];
      PPS_THREE: s = 3'(pg / 5'd3);
      default:   s = pg[2:0];
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  page_sel_r;
  logic [7:0]  freq_hi_r;
  logic [7:0]  freq_lo_r;
  logic [7:0]  sect_prot_r;
  logic [7:0]  opt_hold_r;
  logic [7:0]  trim_bod_r;
  logic [7:0]  trim_osc_r;
  logic [7:0]  trim_adc_r;
  logic [15:0] mem_addr_r;
  logic        trim_loaded_r;
  logic [1:0]  trim_idx_r;
  fmc_state_e  state_r;
  logic [31:0] cnt_r;
  logic [7:0]  fa_wdata_r;
  logic        last_err_r;

  logic [15:0] khz_value;
  assign khz_value = {freq_hi_r, freq_lo_r};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: both address and data must be present, one cycle answer
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go;
  logic        wr_ok;

  assign o_awready = !aw_hold_r && !o_bvalid;
  assign o_wready  = !w_hold_r && !o_bvalid;
  assign wr_go     = aw_hold_r && w_hold_r && !o_bvalid;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= 8'h00;
    end else if (o_awready && i_awvalid) begin
      aw_hold_r <= 1'b1;
      awaddr_r  <= i_awaddr;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      w_hold_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (o_wready && i_wvalid) begin
      w_hold_r <= 1'b1;
      wdata_r  <= i_wdata;
      wstrb_r  <= i_wstrb;
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  logic       wb;
  logic [7:0] wd;
  assign wb = wr_go && wstrb_r[0];
  assign wd = wdata_r[7:0];

  always_comb begin
    case (awaddr_r)
      A_PAGE_SEL, A_CTRL, A_FREQ_HI, A_FREQ_LO, A_SECT_PROT, A_OPTIONS,
      A_TRIM_BOD, A_TRIM_OSC, A_TRIM_ADC, A_MEM_ADDR, A_MEM_DATA: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-written configuration
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      page_sel_r <= 8'h00;
      freq_hi_r  <= 8'h00;
      freq_lo_r  <= 8'h00;
      mem_addr_r <= 16'h0000;
    end else if (wb) begin
      case (awaddr_r)
        A_PAGE_SEL: page_sel_r <= wd;
        A_FREQ_HI:  freq_hi_r  <= wd;
        A_FREQ_LO:  freq_lo_r  <= wd;
        A_MEM_ADDR: mem_addr_r <= wdata_r[15:0];
        default:    mem_addr_r <= mem_addr_r;
      endcase
    end
  end

  // sector protect bits only set, cleared by reset
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sect_prot_r <= 8'h00;
    end else if (wb && awaddr_r == A_SECT_PROT) begin
      sect_prot_r <= sect_prot_r | wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // option holding reset to OPT_RESET; trim shadows loaded from info area after reset
  // info index of the trim byte fetched while the load runs
  logic [INFO_W-1:0] trim_addr;
  always_comb begin
    case (trim_idx_r)
      2'h1:    trim_addr = TRIM_OSC_IDX;
      2'h2:    trim_addr = TRIM_ADC_IDX;
      default: trim_addr = TRIM_BOD_IDX;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      trim_loaded_r <= 1'b0;
      trim_idx_r    <= 2'h0;
      trim_bod_r    <= 8'h00;
      trim_osc_r    <= 8'h00;
      trim_adc_r    <= 8'h00;
      opt_hold_r    <= OPT_RESET;
    end else if (!trim_loaded_r) begin
      // one index per cycle; array answers combinationally on i_info_rdata
      case (trim_idx_r)
        2'h0: trim_bod_r <= i_info_rdata;
        2'h1: trim_osc_r <= i_info_rdata;
        2'h2: trim_adc_r <= i_info_rdata;
        default: trim_loaded_r <= 1'b1;
      endcase
      trim_idx_r <= trim_idx_r + 2'h1;
    end else if (wb) begin
      // trim writes only touch the shadows, never the array
      case (awaddr_r)
        A_TRIM_BOD: trim_bod_r <= wd;
        A_TRIM_OSC: trim_osc_r <= wd;
        A_TRIM_ADC: trim_adc_r <= wd;
        A_OPTIONS:  opt_hold_r <= wd;
        default:    opt_hold_r <= opt_hold_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: info overlay, option bytes, read protect
  logic info_en;
  logic rd_in_info;
  logic rd_in_flash;
  assign info_en     = page_sel_r[INFO_EN_BIT];
  assign rd_in_info  = (i_rd_addr >= INFO_BASE) && (i_rd_addr <= INFO_LAST);
  assign rd_in_flash = i_rd_addr < flash_size;

  // debugger flash reads are refused while option bit OPT_RDPROT_BIT is low: bit low means programmed
  logic rd_prot;
  assign rd_prot = !opt_hold_r[OPT_RDPROT_BIT];

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rd_data    <= 8'h00;
      o_rd_refused <= 1'b0;
    end else if (i_rd_en) begin
      o_rd_refused <= 1'b0;
      if (rd_in_info && info_en) begin
        if (i_rd_addr >= PARTNO_FIRST && i_rd_addr <= PARTNO_LAST) begin
          o_rd_data <= i_info_rdata;
        end else begin
          o_rd_data <= i_info_rdata;
        end
      end else if (i_rd_dbg && rd_prot && rd_in_flash) begin
        o_rd_data    <= 8'h00;
        o_rd_refused <= 1'b1;
      end else if (rd_in_flash) begin
        o_rd_data <= i_fa_rdata;
      end else begin
        o_rd_data <= ERASED_BYTE;
      end
    end
  end

  // the array sees the info select only for overlay reads, never on writes
  assign o_fa_info_sel = i_rd_en && rd_in_info && info_en && (state_r == FMC_IDLE);

  assign o_dm_wr_block = i_dm_wr && !opt_hold_r[OPT_DMWBLK_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // program / erase sequencer
  logic [PAGE_W-1:0] tgt_page;
  logic              page_ok;
  logic              array_ok;
  logic              addr_ok;
  logic              opt_area;
  logic [PAGE_W-1:0] sel_page;
  assign sel_page = page_sel_r[PAGE_W-1:0];
  assign tgt_page = mem_addr_r[OFS_W+PAGE_W-1:OFS_W];
  assign array_ok = opt_hold_r[OPT_WPROT_BIT];
  assign page_ok  = !sect_prot_r[sect_of(sel_page, pages_per_sect)];
  assign addr_ok  = mem_addr_r < flash_size;
  // the option bytes cannot be programmed; only a page 0 erase or a mass erase changes them
  assign opt_area = mem_addr_r < 16'(OPT_BYTES);

  // cycles = ms * kHz + 1; pulse length independent of clock rate
  function automatic logic [31:0] dur(input logic [15:0] us, input logic [15:0] khz);
    logic [31:0] p;
    p = 32'(us) * 32'(khz);
    return (p / 32'(KHZ_PER_MS)) + 32'h0000_0001;
  endfunction

  logic do_prog;
  logic do_page;
  logic do_mass;
  logic prog_sect_ok;
  assign prog_sect_ok = !sect_prot_r[sect_of(tgt_page, pages_per_sect)];
  assign do_prog = wb && awaddr_r == A_MEM_DATA && state_r == FMC_IDLE && array_ok
                   && addr_ok && !opt_area && prog_sect_ok && tgt_page == sel_page;
  assign do_page = wb && awaddr_r == A_CTRL && wd == CMD_PAGE_ERASE && state_r == FMC_IDLE
                   && array_ok && page_ok && (32'(sel_page) * PAGE_BYTES < 32'(flash_size));
  assign do_mass = wb && awaddr_r == A_CTRL && wd == CMD_MASS_ERASE && state_r == FMC_IDLE
                   && array_ok && sect_prot_r == 8'h00;

  logic cmd_seen;
  assign cmd_seen = wb && (awaddr_r == A_CTRL || awaddr_r == A_MEM_DATA);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_r    <= FMC_IDLE;
      cnt_r      <= 32'h0000_0000;
      fa_wdata_r <= ERASED_BYTE;
      last_err_r <= 1'b0;
    end else begin
      case (state_r)
        FMC_IDLE: begin
          if (do_prog) begin
            state_r    <= FMC_PROG;
            cnt_r      <= dur(T_PROG_US, khz_value);
            fa_wdata_r <= wd;
            last_err_r <= 1'b0;
          end else if (do_page) begin
            state_r    <= FMC_PAGE;
            cnt_r      <= dur(T_PAGE_US, khz_value);
            last_err_r <= 1'b0;
          end else if (do_mass) begin
            state_r    <= FMC_MASS;
            cnt_r      <= dur(T_MASS_US, khz_value);
            last_err_r <= 1'b0;
          end else if (cmd_seen && awaddr_r == A_MEM_DATA) begin
            last_err_r <= 1'b1;
          end else if (cmd_seen && (wd == CMD_PAGE_ERASE || wd == CMD_MASS_ERASE)) begin
            last_err_r <= 1'b1;
          end
        end
        FMC_PROG, FMC_PAGE, FMC_MASS: begin
          if (cnt_r == 32'h0000_0001) begin
            state_r <= FMC_IDLE;
          end
          cnt_r <= cnt_r - 32'h0000_0001;
        end
        default: state_r <= FMC_IDLE;
      endcase
    end
  end

  // array address: page, row, column
  assign o_fa_page       = (state_r == FMC_PAGE) ? sel_page :
                           (state_r == FMC_IDLE) ? i_rd_addr[OFS_W+PAGE_W-1:OFS_W] : tgt_page;
  // during the trim load the array index comes from the loader, not the read port
  assign o_fa_row        = !trim_loaded_r ? ROW_W'(trim_addr[INFO_W-1:COL_W]) :
                           (state_r == FMC_IDLE) ? i_rd_addr[OFS_W-1:COL_W]
                                                 : mem_addr_r[OFS_W-1:COL_W];
  assign o_fa_col        = !trim_loaded_r ? trim_addr[COL_W-1:0] :
                           (state_r == FMC_IDLE) ? i_rd_addr[COL_W-1:0]
                                                 : mem_addr_r[COL_W-1:0];
  assign o_fa_wdata      = fa_wdata_r;
  assign o_fa_prog       = state_r == FMC_PROG;
  assign o_fa_erase_page = state_r == FMC_PAGE;
  assign o_fa_erase_mass = state_r == FMC_MASS;

  ////////////////////////////////////////////////////////////////////////////
  // AXI read side, one cycle answer
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    case (i_araddr)
      A_PAGE_SEL:  rd_byte = page_sel_r;
      A_CTRL:      rd_byte = 8'h00;
      A_FREQ_HI:   rd_byte = freq_hi_r;
      A_FREQ_LO:   rd_byte = freq_lo_r;
      A_STATUS:    rd_byte = {5'h00, last_err_r, state_r};
      A_SECT_PROT: rd_byte = sect_prot_r;
      A_OPTIONS:   rd_byte = opt_hold_r;
      A_TRIM_BOD:  rd_byte = trim_bod_r;
      A_TRIM_OSC:  rd_byte = trim_osc_r;
      A_TRIM_ADC:  rd_byte = trim_adc_r;
      A_MEM_ADDR:  rd_byte = 8'h00;
      A_MEM_DATA:  rd_byte = fa_wdata_r;
      default:     rd_ok   = 1'b0;
    endcase
  end

  assign o_arready = !o_rvalid;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= RESP_OKAY;
    end else if (o_arready && i_arvalid) begin
      o_rvalid <= 1'b1;
      o_rdata  <= (i_araddr == A_MEM_ADDR) ? {16'h0000, mem_addr_r} : {24'h000000, rd_byte};
      o_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

endmodule // fmc_ctrl

// *** tb/fmc_flash_model.sv ***
`timescale 1ns/1ps
module fmc_flash_model (
  input  wire logic       i_sys_clk,
  input  wire logic [4:0] i_page,
  input  wire logic [2:0] i_row,
  input  wire logic [5:0] i_col,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_prog,
  input  wire logic       i_erase_page,
  input  wire logic       i_erase_mass,
  output logic [7:0]      o_rdata,
  output logic [7:0]      o_info_rdata
);
  logic [7:0]  arr  [0:16383];
  // no write path at all: the info array is read-only
  logic [7:0]  info [0:127];
  logic [13:0] a;

  assign a = {i_page, i_row, i_col};
  assign o_rdata = arr[a];
  assign o_info_rdata = info[{i_row[0], i_col}];

  initial begin
    for (int i = 0; i < 16384; i++) arr[i] = 8'hFF;
    // part id of 8 letters, padded with ones; trims elsewhere
    for (int i = 0; i < 128; i++)
      info[i] = (i >= 64 && i < 84) ? ((i < 72) ? 8'(i + 1) : 8'hFF) : 8'(8'h5A ^ i);
  end

  // programming can only clear bits, like a real cell
  always @(posedge i_sys_clk) begin
    if (i_prog) arr[a] <= arr[a] & i_wdata;
    if (i_erase_page)
      for (int i = 0; i < 512; i++) arr[14'({i_page, 9'h000} + i)] <= 8'hFF;
    if (i_erase_mass)
      for (int i = 0; i < 16384; i++) arr[i] <= 8'hFF;
  end
endmodule // fmc_flash_model

// *** tb/fmc_asserts.sv ***
`timescale 1ns/1ps
module fmc_asserts
  import fmc_pkg::*;
#(
  parameter logic [2:0] VARIANT = VAR_4K
) (
  input wire logic        i_sys_clk,
  input wire logic        i_srst,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  o_bresp,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [15:0] i_rd_addr,
  input wire logic        i_rd_en,
  input wire logic        i_rd_dbg,
  input wire logic [7:0]  o_rd_data,
  input wire logic        o_rd_refused,
  input wire logic        i_dm_wr,
  input wire logic        o_dm_wr_block,
  input wire logic [4:0]  o_fa_page,
  input wire logic [2:0]  o_fa_row,
  input wire logic [5:0]  o_fa_col,
  input wire logic        o_fa_prog,
  input wire logic        o_fa_erase_page,
  input wire logic        o_fa_erase_mass,
  input wire logic        o_fa_info_sel
);
  localparam int NPG = (VARIANT == VAR_12K) ? 24 : (VARIANT == VAR_8K) ? 16 : (2 << VARIANT);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence rd_taken;
    i_arvalid && o_arready;
  endsequence
  sequence cpu_rd;
    i_rd_en && !i_rd_dbg;
  endsequence
  ////////////////////////////////////////////////////////////////
  AST_R_ANSWER: assert property (rd_taken |=> o_rvalid) else $error("read answer late");
  AST_R_STAND: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  AST_B_STAND: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write answer dropped");
  AST_ONE_OP: assert property ($onehot0({o_fa_prog, o_fa_erase_page, o_fa_erase_mass}))
    else $error("two array operations");
  AST_OPT_BYTES: assert property (o_fa_prog |-> (|{o_fa_page, o_fa_row, o_fa_col[5:1]}))
    else $error("option byte programmed");
  AST_IN_SIZE: assert property (o_fa_prog |-> o_fa_page < NPG)
    else $error("program beyond flash");
  AST_INFO_WIN: assert property (o_fa_info_sel |-> i_rd_addr[15:7] == 9'h1FC)
    else $error("info select outside window");
  AST_REFUSE_SRC: assert property ($rose(o_rd_refused) |-> $past(i_rd_en && i_rd_dbg))
    else $error("refusal without debugger read");
  AST_CPU_OK: assert property (cpu_rd |=> !o_rd_refused)
    else $error("cpu read refused");
  AST_REFUSE_DATA: assert property (o_rd_refused |-> o_rd_data == 8'h00)
    else $error("refused read leaks data");
  AST_DM_BLOCK: assert property (o_dm_wr_block |-> i_dm_wr)
    else $error("block without write");
endmodule // fmc_asserts

// *** tb/fmc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module fmc_ctrl_tb_top;
  import fmc_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, rv, tv;
  logic [3:0]  i_wstrb = 4'hF;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0, i_rd_en = 1'b0, i_rd_dbg = 1'b0;
  logic        i_dm_wr = 1'b0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        o_rd_refused, o_dm_wr_block, o_fa_prog, o_fa_erase_page, o_fa_erase_mass;
  logic        o_fa_info_sel, rf;
  logic [1:0]  o_bresp, o_rresp, rr;
  logic [15:0] i_rd_addr = 16'h0;
  logic [7:0]  o_rd_data, o_fa_wdata, i_fa_rdata, i_info_rdata, d0, prot = 8'h00;
  logic [4:0]  o_fa_page;
  logic [2:0]  o_fa_row;
  logic [5:0]  o_fa_col;
  int          n_errors = 0, cmp_count = 0, seed = 32'hdf67c45a;
  int          mem [int];

  always #50 i_sys_clk = ~i_sys_clk;

  fmc_ctrl #(.VARIANT(VAR_4K)) i_fmc_ctrl (.*);
  fmc_flash_model i_fmc_flash_model (.i_sys_clk(i_sys_clk), .i_page(o_fa_page),
    .i_row(o_fa_row), .i_col(o_fa_col), .i_wdata(o_fa_wdata), .i_prog(o_fa_prog),
    .i_erase_page(o_fa_erase_page), .i_erase_mass(o_fa_erase_mass),
    .o_rdata(i_fa_rdata), .o_info_rdata(i_info_rdata));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // ready is looked at on the falling edge: it cannot move before the next rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'b0;
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    while (!tb && n < 50) begin
      @(negedge i_sys_clk);
      ta = i_awvalid && o_awready;
      tw = i_wvalid && o_wready;
      tb = o_bvalid && i_bready;
      rr = o_bresp;
      @(posedge i_sys_clk);
      if (ta) i_awvalid <= 1'b0;
      if (tw) i_wvalid <= 1'b0;
      // ready rises from the second cycle on, in the same cycle as the write answer, so the slave never holds it
      if (n > 0 && !tb) i_bready <= 1'b1;
      n++;
    end
    i_bready <= 1'b0;
    if (!tb) n_errors++;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic ta, tr;
    n = 0;
    tr = 1'b0;
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    while (!tr && n < 50) begin
      @(negedge i_sys_clk);
      ta = i_arvalid && o_arready;
      tr = o_rvalid && i_rready;
      rv = o_rdata;
      rr = o_rresp;
      @(posedge i_sys_clk);
      if (ta) i_arvalid <= 1'b0;
      if (n > 0 && !tr) i_rready <= 1'b1;
      n++;
    end
    i_rready <= 1'b0;
    if (!tr) n_errors++;
  endtask
  task automatic rp(input logic [15:0] a, input logic dbg);
    @(posedge i_sys_clk);
    i_rd_addr <= a;
    i_rd_dbg <= dbg;
    i_rd_en <= 1'b1;
    @(posedge i_sys_clk);
    i_rd_en <= 1'b0;
    @(negedge i_sys_clk);
    d0 = o_rd_data;
    rf = o_rd_refused;
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      rd(A_STATUS);
      n++;
    end while (rv[1:0] !== 2'h0 && n < 100);
    if (n >= 100) n_errors++;
  endtask
  function automatic logic [7:0] ef(input int a);
    if (mem.exists(a)) return mem[a][7:0];
    return 8'hFF;
  endfunction
  // bench decides acceptance itself, then tracks what the array must hold
  task automatic op(input logic [15:0] a, input logic [7:0] pg);
    logic [7:0] v;
    logic ok;
    v = 8'($random(seed));
    ok = a >= 16'h2 && a < 16'h1000 && a[13:9] == pg[4:0] && !prot[a[11:9]];
    wr(A_PAGE_SEL, {24'h0, pg});
    wr(A_MEM_ADDR, {16'h0, a});
    wr(A_MEM_DATA, {24'h0, v});
    idle();
    chk("refused", 32'(!ok), 32'(rv[2]));
    if (ok) mem[a] = ef(a) & v;
  endtask
  task automatic cmd(input logic [7:0] c, input logic rej);
    wr(A_CTRL, {24'h0, c});
    idle();
    chk("cmd refused", 32'(rej), 32'(rv[2]));
  endtask
  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #3000000;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    rd(A_OPTIONS);
    chk("options reset", 32'hFF, rv);
    rd(8'h3C);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(rr));
    wr(8'h3C, 32'h0);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(rr));
    wr(A_FREQ_HI, 32'h0);
    wr(A_FREQ_LO, 32'h1);
    rd(A_FREQ_LO);
    chk("freq low", 32'h1, rv);
    op(16'h0005, 8'h00);
    op(16'h0205, 8'h01);
    op(16'h0001, 8'h00);
    op(16'h1000, 8'h08);
    op(16'h0400, 8'h01);
    op(16'hFE40, 8'h81);
    for (int a = 0; a < 1024; a += 509) begin
      rp(16'(a), 1'b0);
      chk("flash", 32'(ef(a)), 32'(d0));
    end
    wr(A_PAGE_SEL, 32'h1);
    cmd(CMD_PAGE_ERASE, 1'b0);
    for (int a = 512; a < 1024; a++) mem.delete(a);
    rp(16'h0205, 1'b0);
    chk("erased", 32'hFF, 32'(d0));
    rp(16'h0005, 1'b0);
    chk("kept", 32'(ef(5)), 32'(d0));
    tv = 32'($random(seed)) & 32'hFF;
    wr(A_TRIM_BOD, tv);
    rd(A_TRIM_BOD);
    chk("trim hold", tv, rv);
    rd(A_TRIM_OSC);
    chk("trim resp", 32'(RESP_OKAY), 32'(rr));
    chk("trim osc", 32'h5A ^ 32'(TRIM_OSC_IDX), rv);
    wr(A_PAGE_SEL, 32'h80);
    rp(16'hFE00, 1'b0);
    chk("info trim byte", 32'h5A, 32'(d0));
    for (int k = 0; k < 20; k++) begin
      rp(16'hFE40 + 16'(k), 1'b0);
      chk("part id", (k < 8) ? 32'h41 + k : 32'hFF, 32'(d0));
    end
    wr(A_PAGE_SEL, 32'h0);
    rp(16'hFE40, 1'b0);
    chk("no overlay", 32'hFF, 32'(d0));
    cmd(CMD_MASS_ERASE, 1'b0);
    mem.delete();
    rp(16'h0005, 1'b0);
    chk("mass erased", 32'hFF, 32'(d0));
    wr(A_SECT_PROT, 32'h2);
    prot = 8'h02;
    wr(A_SECT_PROT, 32'h0);
    rd(A_SECT_PROT);
    chk("protect sticky", 32'h2, rv);
    op(16'h0210, 8'h01);
    cmd(CMD_PAGE_ERASE, 1'b1);
    cmd(CMD_MASS_ERASE, 1'b1);
    wr(A_OPTIONS, 32'hFA);
    rp(16'h0005, 1'b1);
    chk("dbg refused", 32'h1, 32'(rf));
    rp(16'h0005, 1'b0);
    chk("cpu allowed", 32'h0, 32'(rf));
    @(posedge i_sys_clk);
    i_dm_wr <= 1'b1;
    @(negedge i_sys_clk);
    chk("dm block", 32'h1, 32'(o_dm_wr_block));
    give_verdict();
  end
endmodule // fmc_ctrl_tb_top

bind fmc_ctrl fmc_asserts #(.VARIANT(VARIANT)) u_fmc_asserts (.*);
